/* hw/incl_spi_consts.vh */
`ifndef INCL_SPI_CONSTS_VH
`define INCL_SPI_CONSTS_VH

// frame shape
`define INCL_FRAME_BITS 16
`define INCL_CNT_W 5
`define INCL_ADDR_W 6
`define INCL_DATA_W 8
`define INCL_LAST_BIT 5'h0f

// command field positions within a received frame
`define INCL_CMD_WR_BIT 15
`define INCL_CMD_ZERO_BIT 14
`define INCL_ADDR_HI 13
`define INCL_ADDR_LO 8
`define INCL_DATA_HI 7

// reset values
`define INCL_TX_RESET 16'h0000
`define INCL_ADDR_RESET 6'h00

// sample period boundary between fast and normal mode
`define INCL_FAST_MAX_SETTING 8'h07

`endif

/* hw/incl_spi_shift.v */
`timescale 1ns/1ps
`default_nettype none
module incl_spi_shift
(
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // control
    input wire clear_i,
    input wire load_i,
    input wire [15:0] load_data_i,
    input wire shift_i,
    input wire sample_i,
    input wire rx_bit_i,
    // state
    output reg [15:0] tx_shift_o,
    output reg [15:0] rx_shift_o
);

    always @(posedge clk_i)
    begin
        if (!rst_b_i || clear_i)
        begin
            tx_shift_o <= 16'h0000;
            rx_shift_o <= 16'h0000;
        end
        else
        begin
            if (load_i)
                tx_shift_o <= load_data_i;
            else if (shift_i)
                tx_shift_o <= {tx_shift_o[14:0], 1'b0};
            if (sample_i)
                rx_shift_o <= {rx_shift_o[14:0], rx_bit_i};
        end
    end

endmodule // incl_spi_shift
`default_nettype wire

/* hw/incl_spi_slave.v */
// Functional notes
// - The output MSB is driven as soon as chip select falls, before any clock edge.
// - Each later output bit is presented after a falling edge of the serial clock.
// - The data input is sampled on each rising edge of the serial clock.
// - The data output is released to high impedance whenever chip select is high.
// - Clock idles high, data changes on falling edges and is captured on rising edges.
// - The active-low reset returns the port to a known initial state.
// - A frame is exactly 16 clock cycles with input and output shifted at once.
// - A write frame is 1, 0, a 6-bit address and 8 data bits, updating one byte.
// - A read frame is 0, 0 and an address; the register comes back in the next frame.
// - With chip select high, clock and data input activity is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "incl_spi_consts.vh"
module incl_spi_slave
(
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // serial pins
    input wire cs_b_i,
    input wire sclk_i,
    input wire din_i,
    output wire dout_o,
    output wire dout_oe_o,
    // mode
    input wire [7:0] sample_period_setting_i,
    output wire fast_mode_o,
    // register side
    input wire [15:0] rd_data_i,
    output reg [5:0] rd_addr_o,
    output reg wr_stb_o,
    output reg [5:0] wr_addr_o,
    output reg [7:0] wr_data_o,
    output reg rd_stb_o,
    output reg frame_abort_o
);

    // frame states; done keeps the last bit on the pin until deselect
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SHIFT = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;

    // two-stage synchronisers; stage one feeds stage two only
    reg cs_m;
    reg cs_s;
    reg sclk_m;
    reg sclk_s;
    reg din_m;
    reg din_s;
    reg sclk_d;
    reg cs_d;
    reg [1:0] frame_state;
    reg [1:0] next_frame_state;
    wire active;
    reg rd_pending;
    reg [`INCL_CNT_W-1:0] bit_cnt;
    wire [15:0] tx_shift;
    wire [15:0] rx_shift;
    wire [15:0] rx_word;
    wire cs_fall;
    wire cs_rise;
    wire sclk_rise;
    wire sclk_fall;
    wire sample_en;
    wire shift_en;
    wire frame_done;

    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            sclk_m <= 1'b1;
            sclk_s <= 1'b1;
            din_m <= 1'b0;
            din_s <= 1'b0;
            sclk_d <= 1'b1;
            cs_d <= 1'b1;
        end
        else
        begin
            cs_m <= cs_b_i;
            cs_s <= cs_m;
            sclk_m <= sclk_i;
            sclk_s <= sclk_m;
            din_m <= din_i;
            din_s <= din_m;
            sclk_d <= sclk_s;
            cs_d <= cs_s;
        end
    end

    assign cs_fall = cs_d && !cs_s;
    assign cs_rise = !cs_d && cs_s;
    // clock idles high; capture on rise, change on fall
    assign sclk_rise = !sclk_d && sclk_s;
    assign sclk_fall = sclk_d && !sclk_s;
    // edges only count inside a frame
    assign sample_en = active && !cs_s && sclk_rise;
    // first falling edge finds the msb already on the pin
    assign shift_en = active && !cs_s && sclk_fall
                      && (bit_cnt != 5'h00);
    assign frame_done = sample_en && (bit_cnt == `INCL_LAST_BIT);
    assign rx_word = {rx_shift[14:0], din_s};
    assign active = (frame_state == ST_SHIFT);

    incl_spi_shift u_shift
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .clear_i(cs_rise),
        .load_i(cs_fall),
        .load_data_i(rd_pending ? rd_data_i : `INCL_TX_RESET),
        .shift_i(shift_en),
        .sample_i(sample_en),
        .rx_bit_i(din_s),
        .tx_shift_o(tx_shift),
        .rx_shift_o(rx_shift)
    );

    // output only while selected; msb visible from the select edge on
    assign dout_o = tx_shift[15];
    assign dout_oe_o = (frame_state != ST_IDLE) && !cs_s;
    assign fast_mode_o = (sample_period_setting_i <= `INCL_FAST_MAX_SETTING);

    // command decode, shared by the strobe and the answer logic
    function is_write_cmd;
        input [15:0] word;
        begin
            is_write_cmd = word[`INCL_CMD_WR_BIT]
                           && !word[`INCL_CMD_ZERO_BIT];
        end
    endfunction

    function is_read_cmd;
        input [15:0] word;
        begin
            is_read_cmd = !word[`INCL_CMD_WR_BIT]
                          && !word[`INCL_CMD_ZERO_BIT];
        end
    endfunction

    // after the 16th rising edge the port waits for deselect
    always @*
    begin
        next_frame_state = frame_state;
        case (frame_state)
            ST_IDLE:
            begin
                if (cs_fall)
                    next_frame_state = ST_SHIFT;
            end
            ST_SHIFT:
            begin
                if (cs_rise)
                    next_frame_state = ST_IDLE;
                else if (frame_done)
                    next_frame_state = ST_DONE;
            end
            ST_DONE:
            begin
                // extra clocks before deselect are ignored
                if (cs_rise)
                    next_frame_state = ST_IDLE;
            end
            default:
                next_frame_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            frame_state <= ST_IDLE;
            bit_cnt <= 5'h00;
            rd_pending <= 1'b0;
            rd_addr_o <= `INCL_ADDR_RESET;
            wr_stb_o <= 1'b0;
            rd_stb_o <= 1'b0;
            wr_addr_o <= `INCL_ADDR_RESET;
            wr_data_o <= 8'h00;
            frame_abort_o <= 1'b0;
        end
        else
        begin
            frame_state <= next_frame_state;
            wr_stb_o <= 1'b0;
            rd_stb_o <= 1'b0;
            frame_abort_o <= 1'b0;
            if (cs_fall)
            begin
                bit_cnt <= 5'h00;
                // answer enters the shifter on this edge; used once only
                rd_pending <= 1'b0;
            end
            else if (cs_rise)
            begin
                // partial frame discarded, no strobe
                frame_abort_o <= active;
                bit_cnt <= 5'h00;
            end
            else if (frame_done)
            begin
                bit_cnt <= 5'h00;
                if (is_write_cmd(rx_word))
                begin
                    wr_stb_o <= 1'b1;
                    wr_addr_o <= rx_word[`INCL_ADDR_HI:`INCL_ADDR_LO];
                    wr_data_o <= rx_word[`INCL_DATA_HI:0];
                end
                else if (is_read_cmd(rx_word))
                begin
                    rd_stb_o <= 1'b1;
                    rd_addr_o <= rx_word[`INCL_ADDR_HI:`INCL_ADDR_LO];
                end
            end
            else if (sample_en)
                bit_cnt <= bit_cnt + 5'h01;
            // set wins: a completed read arms the next frame's answer
            if (frame_done && is_read_cmd(rx_word))
                rd_pending <= 1'b1;
        end
    end

endmodule // incl_spi_slave
`default_nettype wire

/* bench/incl_spi_slave_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module incl_spi_chk
(
    input wire logic clk_i, rst_b_i, cs_b_i, sclk_i, din_i, dout_o,
    input wire logic dout_oe_o, fast_mode_o, wr_stb_o, rd_stb_o,
    input wire logic frame_abort_o,
    input wire logic [7:0] sample_period_setting_i, wr_data_o,
    input wire logic [15:0] rd_data_i,
    input wire logic [5:0] rd_addr_o, wr_addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_oe_on: assert property ($fell(cs_b_i) |-> ##[3:5] dout_oe_o)
        else $error("output not driven");
    chk_oe_off: assert property ($rose(cs_b_i) |-> ##[3:5] !dout_oe_o)
        else $error("output not released");
    chk_idle_hiz: assert property (cs_b_i [*6] |-> !dout_oe_o)
        else $error("driven while idle");
    chk_idle_quiet: assert property (cs_b_i [*6] |->
        !wr_stb_o && !rd_stb_o) else $error("strobe while idle");
    chk_stb_pulse: assert property ((wr_stb_o || rd_stb_o) |->
        !cs_b_i ##1 !(wr_stb_o || rd_stb_o)) else $error("bad strobe");
    chk_abort_pulse: assert property (frame_abort_o |->
        cs_b_i && !wr_stb_o ##1 !frame_abort_o) else $error("bad abort");
    chk_fast_flag: assert property (fast_mode_o ==
        (sample_period_setting_i <= 8'h07)) else $error("bad mode flag");
    chk_dout_step: assert property (
        dout_oe_o && $past(dout_oe_o) && $changed(dout_o)
        |-> !$past(sclk_i, 2) || !$past(sclk_i, 3))
        else $error("output moved without falling clock");
    chk_oe_hold: assert property ($fell(dout_oe_o) |->
        $past(cs_b_i, 2)) else $error("output released inside frame");
endmodule // incl_spi_chk
bind incl_spi_slave incl_spi_chk chk_u (.clk_i, .rst_b_i, .cs_b_i, .sclk_i,
    .din_i, .dout_o, .dout_oe_o, .fast_mode_o, .wr_stb_o, .rd_stb_o,
    .frame_abort_o, .sample_period_setting_i, .wr_data_o, .rd_data_i,
    .rd_addr_o, .wr_addr_o);
`default_nettype wire

/* bench/incl_host.sv */
`timescale 1ns/1ps
`default_nettype none
module incl_host
(
    input wire logic clk_i,
    input wire logic sdo_i,
    output var logic cs_b_o,
    output var logic sclk_o,
    output var logic sdi_o
);
    initial {cs_b_o, sclk_o, sdi_o} = 3'b110;
    // idle data wanders so a stale bit never looks valid
    always @(posedge clk_i) if (cs_b_o) sdi_o <= ~sdi_o;
    task automatic frame(input logic [15:0] tx, input int n,
        output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk_i) cs_b_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            sclk_o <= 1'b0;
            sdi_o <= tx[15 - i];
            repeat (4) @(posedge clk_i);
            // take each bit as the clock rises, never at the fall
            rx[15 - i] = sdo_i;
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        repeat (2) @(posedge clk_i);
        cs_b_o <= 1'b1;
        // gap kept short to save run time; the port holds no gap timer
        repeat (40) @(posedge clk_i);
    endtask
endmodule // incl_host
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] setting = 8'h00;
    logic [15:0] rd_data_i = 16'h0000;
    logic [15:0] rx, want, tx;
    logic [5:0] a;
    logic [7:0] d;
    wire cs_b_i, sclk_i, din_i, dout_o, dout_oe_o, fast_mode_o;
    wire wr_stb_o, rd_stb_o, frame_abort_o;
    wire [5:0] rd_addr_o, wr_addr_o;
    wire [7:0] wr_data_o;
    wire sdo = dout_oe_o ? dout_o : 1'bz;
    int errors = 0, checks_done = 0, seed = 32'h8c5c, kind;
    int nwr = 0, nrd = 0, nab = 0, ewr = 0, erd = 0, eab = 0;
    incl_host host_u (.clk_i, .sdo_i(sdo), .cs_b_o(cs_b_i), .sclk_o(sclk_i),
        .sdi_o(din_i));
    incl_spi_slave dut_u (.clk_i, .rst_b_i, .cs_b_i, .sclk_i, .din_i, .dout_o,
        .dout_oe_o, .sample_period_setting_i(setting), .fast_mode_o,
        .rd_data_i, .rd_addr_o, .wr_stb_o, .wr_addr_o, .wr_data_o, .rd_stb_o,
        .frame_abort_o);
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        rd_data_i <= {rd_addr_o, ~rd_addr_o, 4'h5};
        if (rst_b_i)
        begin
            nwr <= nwr + wr_stb_o;
            nrd <= nrd + rd_stb_o;
            nab <= nab + frame_abort_o;
        end
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        end_of_test;
    end
    initial
    begin
        want = 16'h0000;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (int k = 0; k < 24; k++)
        begin
            kind = (k == 11) ? 1 : (k < 4) ? k : {$random(seed)} % 4;
            a = $random(seed);
            d = $random(seed);
            setting <= k[7:0];
            // kind 3 sends the unused 1,1 code, which must do nothing
            tx = {kind == 0 || kind == 3, kind == 3, a, d};
            host_u.frame(tx, (kind == 2) ? 8 : 16, rx);
            want[7:0] = (kind == 2) ? 8'h00 : want[7:0];
            `CHK("answer", want, rx)
            ewr += (kind == 0);
            erd += (kind == 1);
            eab += (kind == 2);
            `CHK("writes", ewr, nwr)
            `CHK("reads", erd, nrd)
            `CHK("aborts", eab, nab)
            `CHK("fast", setting <= 8'h07, fast_mode_o)
            if (kind == 0) `CHK("wdata", {a, d}, {wr_addr_o, wr_data_o})
            if (kind == 1) `CHK("raddr", a, rd_addr_o)
            want = (kind == 1) ? {a, ~a, 4'h5} : 16'h0000;
            if (k == 11)
            begin
                rst_b_i <= 1'b0;
                repeat (3) @(posedge clk_i);
                `CHK("oe", 1'b0, dout_oe_o)
                `CHK("raddr", 6'h00, rd_addr_o)
                rst_b_i <= 1'b1;
                want = 16'h0000;
                repeat (4) @(posedge clk_i);
            end
        end
        end_of_test;
    end
endmodule // tb
`default_nettype wire
